// ### hw/fault_limit_consts.vh
// Constants for the fault, status and limit register bank.
// Assumes a byte-wide register port driven by a serial protocol engine elsewhere.
`ifndef FAULT_LIMIT_CONSTS_VH
`define FAULT_LIMIT_CONSTS_VH

`define ADDR_OC_WARN_LIMIT   8'h20
`define ADDR_SUMMARY_STATUS  8'h21
`define ADDR_FAULT_MASK      8'h22
`define ADDR_FAULT_STATUS    8'h23
`define ADDR_WARNING_STATUS  8'h24
`define ADDR_CURRENT_READING 8'h26
`define ADDR_LOCK_CONTROL    8'h2a
`define ADDR_RAMP_STRAP      8'h2b
`define ADDR_OC_STRAP        8'h2d
`define ADDR_OC_OVERRIDE     8'h2e
`define ADDR_SECOND_FUNC_A   8'h46
`define ADDR_SECOND_FUNC_B   8'h47

`define RST_OC_WARN_LIMIT    8'hff
`define RST_ZERO             8'h00

`define SUM_OV_BIT           5
`define SUM_OC_BIT           4
`define FLT_TOTAL_A_BIT      4
`define FLT_TOTAL_B_BIT      3
`define FLT_PHASE_BIT        2
`define FLT_OV_BIT           1
`define FLT_UV_BIT           0
`define WARN_OC_BIT          0
`define LOCK_BIT             0
`define SF_OC_OVERRIDE_BIT   0

`define FAULT_FIELD_W        5
`define RAMP_FIELD_W         4
`define OC_FIELD_W           4
`define OC_THRESH_HI         3
`define OC_THRESH_LO         2
`define OC_DELAY_HI          1
`define OC_DELAY_LO          0

`endif

// ### hw/edge_sync.v
// Two-flop synchroniser with a rising-edge pulse on the synchronised level.
// Assumes the input is asynchronous to clk_in.
`timescale 1ns/1ns
module edge_sync (
  input  wire clk_in,   // System clock
  input  wire rst_in,   // Synchronous reset, active high
  input  wire async_in, // Raw level from a pin
  output wire level_out,// Synchronised level
  output wire rise_out  // One-cycle pulse on rising edge
);
  reg meta_q;
  reg sync_q;
  reg prev_q;

  always @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out  = sync_q & ~prev_q;
endmodule // edge_sync

// ### hw/fault_status_limit_registers.v
// Telemetry, fault and configuration register bank of a multiphase controller.
// Assumes a protocol engine presents complete byte-register writes and reads
// on a simple strobe port, and analog monitors deliver event levels as pins.
`timescale 1ns/1ns
`include "fault_limit_consts.vh"
module fault_status_limit_registers (
  input  wire       CLK_SYS_IN,        // 50 MHz system clock
  input  wire       RST_IN,            // Synchronous reset, active high
  input  wire       PWR_ON_RST_IN,     // Power-up reset, only this clears the lock
  input  wire       REG_WR_IN,         // Register write strobe
  input  wire       REG_RD_IN,         // Register read strobe
  input  wire [7:0] REG_ADDR_IN,       // Register address
  input  wire [7:0] REG_WDATA_IN,      // Write data
  output reg  [7:0] REG_RDATA_OUT,     // Read data, valid cycle after read
  output wire       REG_ACK_OUT,       // Access accepted, one cycle
  input  wire       ENABLE_IN,         // Enable pin
  input  wire [7:0] CURRENT_CODE_IN,   // Current monitor conversion result
  input  wire       TOTAL_LIMIT_A_IN,  // Total current limit one exceeded
  input  wire       TOTAL_LIMIT_B_IN,  // Total current limit two exceeded
  input  wire       PHASE_LIMIT_IN,    // Phase sense difference over threshold
  input  wire       OV_EVENT_IN,       // Overvoltage protection entered
  input  wire       UV_EVENT_IN,       // Undervoltage event detected
  input  wire       OC_LATCHOFF_IN,    // Overcurrent latch-off occurred
  input  wire [3:0] RAMP_STRAP_IN,     // Ramp strap resistor decode
  input  wire [3:0] OC_STRAP_IN,       // Overcurrent strap resistor decode
  output reg        ALERT_OUT,         // Alert, high while warning is set
  output reg  [1:0] OC_THRESHOLD_OUT,  // Active per-phase threshold code
  output reg  [1:0] OC_DELAY_OUT,      // Active latch-off delay code
  output reg  [3:0] RAMP_CODE_OUT      // Active ramp code
);
  // Pin synchronisers
  wire       en_level;
  wire       en_rise;
  reg  [7:0] cur_meta_q;
  reg  [7:0] cur_q;
  reg  [5:0] ev_meta_q;
  reg  [5:0] ev_q;
  reg  [7:0] strap_meta_q;
  reg  [7:0] strap_q;

  edge_sync u_en_sync (
    .clk_in    (CLK_SYS_IN),
    .rst_in    (RST_IN),
    .async_in  (ENABLE_IN),
    .level_out (en_level),
    .rise_out  (en_rise)
  );

  // Multi-bit code assumed stable between conversions
  always @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      cur_meta_q   <= `RST_ZERO;
      cur_q        <= `RST_ZERO;
      ev_meta_q    <= 6'h00;
      ev_q         <= 6'h00;
      strap_meta_q <= `RST_ZERO;
      strap_q      <= `RST_ZERO;
    end else begin
      cur_meta_q   <= CURRENT_CODE_IN;
      cur_q        <= cur_meta_q;
      ev_meta_q    <= {OC_LATCHOFF_IN, OV_EVENT_IN, TOTAL_LIMIT_A_IN,
                       TOTAL_LIMIT_B_IN, PHASE_LIMIT_IN, UV_EVENT_IN};
      ev_q         <= ev_meta_q;
      strap_meta_q <= {RAMP_STRAP_IN, OC_STRAP_IN};
      strap_q      <= strap_meta_q;
    end
  end

  wire ev_uv      = ev_q[0];
  wire ev_phase   = ev_q[1];
  wire ev_total_b = ev_q[2];
  wire ev_total_a = ev_q[3];
  wire ev_ov      = ev_q[4];
  wire ev_latch   = ev_q[5];

  // Registers
  reg  [7:0] warn_limit_q;
  reg  [7:0] fault_mask_q;
  reg  [7:0] fault_status_q;
  reg  [7:0] summary_q;
  reg        warn_flag_q;
  reg  [7:0] reading_q;
  reg        lock_q;
  reg  [3:0] ramp_strap_q;
  reg  [3:0] oc_strap_q;
  reg  [3:0] oc_override_q;
  reg  [7:0] second_a_q;
  reg  [7:0] second_b_q;
  reg        ack_q;

  wire wr_limit  = REG_WR_IN && (REG_ADDR_IN == `ADDR_OC_WARN_LIMIT);
  wire wr_mask   = REG_WR_IN && (REG_ADDR_IN == `ADDR_FAULT_MASK);
  wire wr_lock   = REG_WR_IN && (REG_ADDR_IN == `ADDR_LOCK_CONTROL);
  wire wr_ovr    = REG_WR_IN && (REG_ADDR_IN == `ADDR_OC_OVERRIDE);
  wire wr_sfa    = REG_WR_IN && (REG_ADDR_IN == `ADDR_SECOND_FUNC_A);
  wire wr_sfb    = REG_WR_IN && (REG_ADDR_IN == `ADDR_SECOND_FUNC_B);

  // Lock is not cleared by the ordinary reset, only by power-up
  always @(posedge CLK_SYS_IN) begin
    if (PWR_ON_RST_IN) begin
      lock_q <= 1'b0;
    end else if (wr_lock && REG_WDATA_IN[`LOCK_BIT]) begin
      lock_q <= 1'b1;
    end
  end

  // Lockable registers: limit, mask, override and function latches
  always @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      warn_limit_q  <= `RST_OC_WARN_LIMIT;
      fault_mask_q  <= `RST_ZERO;
      oc_override_q <= 4'h0;
      second_a_q    <= `RST_ZERO;
      second_b_q    <= `RST_ZERO;
    end else begin
      if (!lock_q) begin
        if (wr_limit)
          warn_limit_q <= REG_WDATA_IN;
        if (wr_mask)
          fault_mask_q <= {3'h0, REG_WDATA_IN[`FAULT_FIELD_W-1:0]};
        if (wr_ovr)
          oc_override_q <= REG_WDATA_IN[`OC_FIELD_W-1:0];
        if (wr_sfa)
          second_a_q <= REG_WDATA_IN;
        if (wr_sfb)
          second_b_q <= REG_WDATA_IN;
      end
    end
  end

  // Current reading and status
  wire warn_hit = (reading_q > warn_limit_q);
  wire [`FAULT_FIELD_W-1:0] fault_ev = {ev_total_a, ev_total_b, ev_phase, ev_ov, ev_uv};

  always @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      reading_q      <= `RST_ZERO;
      warn_flag_q    <= 1'b0;
      fault_status_q <= `RST_ZERO;
      summary_q      <= `RST_ZERO;
      ALERT_OUT      <= 1'b0;
    end else begin
      // Full-scale code 0xff at 2 V
      reading_q <= cur_q;
      // Only an enable rise clears it; set wins
      if (warn_hit)
        warn_flag_q <= 1'b1;
      else if (en_rise)
        warn_flag_q <= 1'b0;
      ALERT_OUT <= warn_hit | (warn_flag_q & ~en_rise);
      // Mask write clears; event in same cycle wins
      fault_status_q[`FAULT_FIELD_W-1:0] <=
        (fault_status_q[`FAULT_FIELD_W-1:0] &
         ~(wr_mask && !lock_q ? REG_WDATA_IN[`FAULT_FIELD_W-1:0] : 5'h00)) |
        (fault_ev & fault_mask_q[`FAULT_FIELD_W-1:0]);
      if (ev_ov)
        summary_q[`SUM_OV_BIT] <= 1'b1;
      if (ev_latch)
        summary_q[`SUM_OC_BIT] <= 1'b1;
    end
  end

  // Strap capture on each enable rise
  always @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      ramp_strap_q <= 4'h0;
      oc_strap_q   <= 4'h0;
    end else if (en_rise) begin
      ramp_strap_q <= strap_q[7:4];
      oc_strap_q   <= strap_q[3:0];
    end
  end

  wire override_on = second_a_q[`SF_OC_OVERRIDE_BIT] & second_b_q[`SF_OC_OVERRIDE_BIT];
  wire [3:0] oc_active = override_on ? oc_override_q : oc_strap_q;

  always @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      OC_THRESHOLD_OUT <= 2'h0;
      OC_DELAY_OUT     <= 2'h0;
      RAMP_CODE_OUT    <= 4'h0;
    end else begin
      OC_THRESHOLD_OUT <= oc_active[`OC_THRESH_HI:`OC_THRESH_LO];
      OC_DELAY_OUT     <= oc_active[`OC_DELAY_HI:`OC_DELAY_LO];
      RAMP_CODE_OUT    <= ramp_strap_q;
    end
  end

  // Read port; unmapped addresses read zero
  always @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      REG_RDATA_OUT <= `RST_ZERO;
      ack_q         <= 1'b0;
    end else begin
      ack_q <= REG_WR_IN | REG_RD_IN;
      if (REG_RD_IN) begin
        if (REG_ADDR_IN == `ADDR_OC_WARN_LIMIT)
          REG_RDATA_OUT <= warn_limit_q;
        else if (REG_ADDR_IN == `ADDR_SUMMARY_STATUS)
          REG_RDATA_OUT <= summary_q;
        else if (REG_ADDR_IN == `ADDR_FAULT_MASK)
          REG_RDATA_OUT <= fault_mask_q;
        else if (REG_ADDR_IN == `ADDR_FAULT_STATUS)
          REG_RDATA_OUT <= fault_status_q;
        else if (REG_ADDR_IN == `ADDR_WARNING_STATUS)
          REG_RDATA_OUT <= {7'h00, warn_flag_q};
        else if (REG_ADDR_IN == `ADDR_CURRENT_READING)
          REG_RDATA_OUT <= reading_q;
        else if (REG_ADDR_IN == `ADDR_LOCK_CONTROL)
          REG_RDATA_OUT <= {7'h00, lock_q};
        else if (REG_ADDR_IN == `ADDR_RAMP_STRAP)
          REG_RDATA_OUT <= {4'h0, ramp_strap_q};
        else if (REG_ADDR_IN == `ADDR_OC_STRAP)
          REG_RDATA_OUT <= {4'h0, oc_strap_q};
        else if (REG_ADDR_IN == `ADDR_OC_OVERRIDE)
          REG_RDATA_OUT <= {4'h0, oc_override_q};
        else if (REG_ADDR_IN == `ADDR_SECOND_FUNC_A)
          REG_RDATA_OUT <= second_a_q;
        else if (REG_ADDR_IN == `ADDR_SECOND_FUNC_B)
          REG_RDATA_OUT <= second_b_q;
        else
          REG_RDATA_OUT <= `RST_ZERO;
      end
    end
  end

  assign REG_ACK_OUT = ack_q;

  wire unused_en = en_level;
endmodule // fault_status_limit_registers

// ### dv/reg_host.sv
// Host model for the register port: one strobe per byte.
// Assumes tb holds bad_count and report_and_stop.
`timescale 1ns/1ns
module reg_host (
  input  wire       clk_in,   // Clock
  input  wire       ack_in,   // Access accepted
  output reg        wr_out,   // Write strobe
  output reg        rd_out,   // Read strobe
  output reg  [7:0] addr_out, // Address
  output reg  [7:0] data_out  // Write data
);
  initial {wr_out, rd_out, addr_out, data_out} = 18'h0;
  task xfer(input bit w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_in);
    {wr_out, rd_out, addr_out, data_out} <= {w, !w, a, d};
    @(posedge clk_in);
    // Released lines flip so stale values never pass
    {wr_out, rd_out, addr_out, data_out} <= {2'b00, ~a, ~d};
    for (n = 0; n < 8 && !ack_in; n++) @(negedge clk_in);
    if (n == 8) begin
      tb.bad_count++;
      tb.report_and_stop();
    end
  endtask
endmodule // reg_host

// ### dv/fault_status_limit_registers_assertions.sv
// Port checker for the register bank.
// Assumes strobe pulses and registered outputs.
`timescale 1ns/1ns
module fault_status_limit_registers_chk (
  input wire       CLK_SYS_IN,       // Clock
  input wire       RST_IN,           // Reset
  input wire       PWR_ON_RST_IN,    // Power-up reset
  input wire       REG_WR_IN,        // Write
  input wire       REG_RD_IN,        // Read
  input wire [7:0] REG_ADDR_IN,      // Address
  input wire [7:0] REG_RDATA_OUT,    // Read data
  input wire       REG_ACK_OUT,      // Ack
  input wire       ENABLE_IN,        // Enable
  input wire       ALERT_OUT,        // Alert
  input wire [1:0] OC_THRESHOLD_OUT, // Threshold
  input wire [1:0] OC_DELAY_OUT,     // Delay
  input wire [3:0] RAMP_CODE_OUT     // Ramp
);
  // Starts low so the age counter never picks up an unknown
  reg       en_q = 1'b0;
  reg [3:0] en_age_q = 4'hf;
  reg [3:0] wr_age_q = 4'hf;
  // Raw pin age, so sync latency stays inside the bound
  always @(posedge CLK_SYS_IN) begin
    en_q <= ENABLE_IN;
    en_age_q <= (ENABLE_IN && !en_q) ? 4'h0 : en_age_q + {3'h0, en_age_q != 4'hf};
    wr_age_q <= REG_WR_IN ? 4'h0 : wr_age_q + {3'h0, wr_age_q != 4'hf};
  end
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN || PWR_ON_RST_IN);
  AST_ACK_FOLLOWS: assert property ((REG_WR_IN || REG_RD_IN) |=> REG_ACK_OUT)
    else $error("no ack");
  AST_ACK_CAUSE: assert property (REG_ACK_OUT |-> $past(REG_WR_IN) || $past(REG_RD_IN))
    else $error("stray ack");
  AST_RDATA_HOLD: assert property (!REG_RD_IN |=> $stable(REG_RDATA_OUT))
    else $error("read data moved");
  AST_WARN_READ: assert property (REG_RD_IN && REG_ADDR_IN == 8'h24 |=> REG_RDATA_OUT == {7'h0, ALERT_OUT})
    else $error("warning and alert differ");
  AST_ALERT_FALL: assert property ($fell(ALERT_OUT) |-> en_age_q < 4'ha)
    else $error("alert fell without enable");
  AST_RAMP_HELD: assert property ($changed(RAMP_CODE_OUT) |-> en_age_q < 4'ha)
    else $error("ramp moved");
  AST_OC_HELD: assert property ($changed({OC_THRESHOLD_OUT, OC_DELAY_OUT}) |-> en_age_q < 4'ha || wr_age_q < 4'h4)
    else $error("overcurrent code moved");
  AST_FAULT_RSVD: assert property (REG_RD_IN && REG_ADDR_IN[7:1] == 7'h11 |=> REG_RDATA_OUT[7:5] == 3'h0)
    else $error("fault reserved bits set");
  cover property ($rose(ALERT_OUT));
  cover property ($changed(OC_DELAY_OUT) && wr_age_q < 4'h4);
  cover property (REG_WR_IN ##1 REG_ACK_OUT);
endmodule // fault_status_limit_registers_chk
bind fault_status_limit_registers fault_status_limit_registers_chk fault_status_limit_registers_chk_inst (.*);

// ### dv/tb.sv
// Self-checking bench of the register bank.
// Assumes reg_host drives the register port.
`timescale 1ns/1ns
module tb;
  reg         clk, rst, por, en, la, lb, ph, ov, uv, oc, rd_last;
  reg  [7:0]  cur, lim, r;
  reg  [3:0]  rs, os;
  reg  [31:0] seed = 32'h4b51;
  reg  [7:0]  exp_q[$];
  wire        wr, rd, ack, alert;
  wire [7:0]  addr, wd, rdata;
  wire [1:0]  thr, dly;
  wire [3:0]  ramp;
  int         bad_count, checks_done, i;
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  reg_host reg_host_inst (.clk_in(clk), .ack_in(ack), .wr_out(wr), .rd_out(rd), .addr_out(addr), .data_out(wd));
  fault_status_limit_registers fault_status_limit_registers_inst (.CLK_SYS_IN(clk), .RST_IN(rst),
    .PWR_ON_RST_IN(por), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_ADDR_IN(addr), .REG_WDATA_IN(wd),
    .REG_RDATA_OUT(rdata), .REG_ACK_OUT(ack), .ENABLE_IN(en), .CURRENT_CODE_IN(cur), .TOTAL_LIMIT_A_IN(la),
    .TOTAL_LIMIT_B_IN(lb), .PHASE_LIMIT_IN(ph), .OV_EVENT_IN(ov), .UV_EVENT_IN(uv), .OC_LATCHOFF_IN(oc),
    .RAMP_STRAP_IN(rs), .OC_STRAP_IN(os), .ALERT_OUT(alert), .OC_THRESHOLD_OUT(thr), .OC_DELAY_OUT(dly),
    .RAMP_CODE_OUT(ramp));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    reg_host_inst.xfer(1'b1, a, d);
  endtask
  task rd_reg(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_host_inst.xfer(1'b0, a, 8'h00);
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Read results pair with the oldest note
  always @(posedge clk) begin
    if (ack && rd_last && exp_q.size() > 0) chk(rdata, exp_q.pop_front());
    rd_last <= rd;
  end
  initial begin
    {la, lb, ph, ov, uv, oc, cur, rs, os} = 22'h0;
    {rst, por, en} = 3'b110;
    tick(5);
    {rst, por} <= 2'b00;
    wr_reg(8'h31, 8'h5a);
    rd_reg(8'h20, 8'hff);
    seed = lfsr(seed);
    lim = {1'b0, seed[6:0]} + 8'h10;
    wr_reg(8'h20, lim);
    tick(1);
    cur <= lim;
    tick(8);
    chk({7'h0, alert}, 8'h00);
    cur <= lim + 8'h01;
    tick(8);
    chk({7'h0, alert}, 8'h01);
    rd_reg(8'h26, lim + 8'h01);
    wr_reg(8'h20, 8'hff);
    tick(1);
    cur <= 8'h00;
    tick(6);
    rd_reg(8'h24, 8'h01);
    tick(1);
    en <= 1;
    tick(8);
    chk({7'h0, alert}, 8'h00);
    $display("warning done");
    for (i = 0; i < 5; i++) begin
      tick(1);
      {la, lb, ph, ov, uv} <= 5'h01 << i;
      tick(5);
      rd_reg(8'h23, 8'h00);
      wr_reg(8'h22, 8'h1f);
      tick(2);
      rd_reg(8'h23, 8'h01 << i);
      {la, lb, ph, ov, uv} <= 5'h00;
      tick(4);
      wr_reg(8'h22, 8'h1f);
      rd_reg(8'h23, 8'h00);
      wr_reg(8'h22, 8'h00);
    end
    tick(1);
    oc <= 1;
    tick(5);
    rd_reg(8'h21, 8'h30);
    $display("fault done");
    for (i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      r = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[7:0];
      tick(1);
      {en, rs, os} <= {1'b0, r[3:0], r[7:4]};
      tick(4);
      en <= 1;
      tick(8);
      {rs, os} <= ~r;
      tick(8);
      chk({4'h0, ramp}, {4'h0, r[3:0]});
      chk({4'h0, thr, dly}, {4'h0, r[7:4]});
      rd_reg(8'h2b, {4'h0, r[3:0]});
      rd_reg(8'h2d, {4'h0, r[7:4]});
    end
    wr_reg(8'h2e, {4'h0, ~r[7:4]});
    wr_reg(8'h46, 8'h01);
    tick(3);
    chk({4'h0, thr, dly}, {4'h0, r[7:4]});
    wr_reg(8'h47, 8'h01);
    tick(3);
    chk({4'h0, thr, dly}, {4'h0, ~r[7:4]});
    wr_reg(8'h2e, {4'h0, ~r[7:6], r[5:4]});
    tick(3);
    chk({4'h0, thr, dly}, {4'h0, ~r[7:6], r[5:4]});
    $display("strap done");
    wr_reg(8'h2a, 8'h01);
    wr_reg(8'h20, 8'h55);
    rd_reg(8'h20, 8'hff);
    tick(1);
    {rst, en} <= 2'b10;
    tick(3);
    rst <= 0;
    wr_reg(8'h20, 8'h55);
    rd_reg(8'h20, 8'hff);
    tick(1);
    por <= 1;
    tick(3);
    por <= 0;
    wr_reg(8'h20, 8'h55);
    rd_reg(8'h20, 8'h55);
    tick(2);
    $display("lock done");
    if (exp_q.size() != 0) bad_count++;
    report_and_stop();
  end
endmodule // tb
